//--- core/dprpg_defines.svh
`ifndef DPRPG_DEFINES_SVH
`define DPRPG_DEFINES_SVH

// register indices; byte address is four times the index
`define DPRPG_IDX_CTRL0   8'h30
`define DPRPG_IDX_CTRL1   8'h31
`define DPRPG_IDX_LO0     8'h32
`define DPRPG_IDX_HI0     8'h33
`define DPRPG_IDX_LO1     8'h34
`define DPRPG_IDX_HI1     8'h35
`define DPRPG_IDX_COUNT   8'h36
`define DPRPG_ADDR_LSB    2

// control field positions, within the low byte of each control word
`define DPRPG_B_RUN       7
`define DPRPG_B_CSEL1     6
`define DPRPG_B_PIN       5
`define DPRPG_B_IRQ       4
`define DPRPG_B_FLAG      3
`define DPRPG_B_SEL_HI    2
`define DPRPG_B_SEL_LO    1
`define DPRPG_B_RSV       0

// clock select and mode codes
`define DPRPG_CS_CLK      2'b00
`define DPRPG_CS_DIV4     2'b01
`define DPRPG_CS_DIV16    2'b10
`define DPRPG_CS_TB       2'b11
`define DPRPG_MD_INDEP    2'b00
`define DPRPG_MD_PRESC    2'b01
`define DPRPG_MD_WIDE     2'b11

// divider taps and counter values
`define DPRPG_DIV4_END    4'h3
`define DPRPG_DIV16_END   4'hf
`define DPRPG_DIV_STEP    4'h1
`define DPRPG_CNT_ZERO    8'h00
`define DPRPG_CNT_WRAP    8'hff
`define DPRPG_CNT_STEP    8'h01

// reset values
`define DPRPG_RST_BYTE    8'h00
`define DPRPG_RST_WORD    32'h0000_0000
`define DPRPG_RST_SEL     2'b00

`endif

//--- core/dprpg_pkg.sv
`default_nettype none
`include "dprpg_defines.svh"

package dprpg_pkg;

    // per-channel drive from the top into a counter engine
    typedef struct packed {
        logic       run;
        logic       tick;
        logic       reload_now;
        logic [7:0] lo;
        logic [7:0] hi;
    } dprpg_chcfg_t;

    // counter engine state
    typedef struct packed {
        logic       active;
        logic       level;
        logic [7:0] cnt;
    } dprpg_chst_t;

    // control fields of one channel
    typedef struct packed {
        logic       run;
        logic       csel1;
        logic       pin;
        logic       irq;
        logic       flag;
        logic [1:0] sel;
    } dprpg_ctrl_t;

    // whole state of the top module
    typedef struct packed {
        logic [3:0]  div;
        dprpg_ctrl_t c0;
        dprpg_ctrl_t c1;
        logic [1:0]  mode;
        logic [7:0]  lo0;
        logic [7:0]  hi0;
        logic [7:0]  lo1;
        logic [7:0]  hi1;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        out_a;
        logic        out_b;
        logic        oe_a;
        logic        oe_b;
        logic        irq0;
        logic        irq1;
    } dprpg_st_t;

endpackage

`default_nettype wire

//--- core/dprpg_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "dprpg_defines.svh"

module dprpg_chan
    import dprpg_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire dprpg_chcfg_t cfg_i,
    output logic              borrow_o,
    output logic              level_o,
    output logic [7:0]        cnt_o
);

    dprpg_chst_t st_r;
    dprpg_chst_t st_nxt;

    // ****************************************
    // counter engine
    // ****************************************

    // next state; borrow is a same-cycle pulse so a cascaded channel sees it at once
    always_comb begin
        st_nxt   = st_r;
        borrow_o = 1'b0;
        if (!cfg_i.run) begin
            st_nxt.active = 1'b0;
            st_nxt.level  = 1'b0;
        end else if (!st_r.active) begin
            st_nxt.active = 1'b1;
            st_nxt.level  = 1'b0;
            st_nxt.cnt    = cfg_i.lo;
        end else if (cfg_i.tick) begin
            if (st_r.cnt == `DPRPG_CNT_ZERO) begin
                borrow_o = 1'b1;
                if (cfg_i.reload_now) begin
                    st_nxt.level = ~st_r.level;
                    st_nxt.cnt   = st_r.level ? cfg_i.lo : cfg_i.hi;
                end else begin
                    // low byte of a joined counter just wraps
                    st_nxt.cnt = `DPRPG_CNT_WRAP;
                end
            end else begin
                // value plus one ticks per phase
                st_nxt.cnt = st_r.cnt - `DPRPG_CNT_STEP;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.level;
    assign cnt_o   = st_r.cnt;

endmodule

`default_nettype wire

//--- core/dprpg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dprpg_defines.svh"

module dprpg_top
    import dprpg_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [9:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        TB_TICK_I,
    output logic             PULSE_OUT_A_O,
    output logic             PULSE_OE_A_O,
    output logic             PULSE_OUT_B_O,
    output logic             PULSE_OE_B_O,
    output logic             IRQ_CH0_O,
    output logic             IRQ_CH1_O
);

    dprpg_st_t    st_r;
    dprpg_st_t    st_nxt;
    dprpg_chcfg_t cfg [2];
    logic [1:0]   borrow;
    logic [1:0]   level;
    logic [7:0]   cnt [2];
    logic         tick0;
    logic         tick1;
    logic         wide;
    logic         presc;
    logic         wr_acc;
    logic         rd_setup;
    logic [7:0]   idx;
    logic         set0;
    logic         set1;

    // ****************************************
    // count clock selection
    // ****************************************

    // mode decode; the reserved code falls back to independent channels
    // mode decode
    assign wide  = (st_r.mode == `DPRPG_MD_WIDE);
    assign presc = (st_r.mode == `DPRPG_MD_PRESC);

    // channel 0 tick from a free divider; the divider is never reset by
    // software, so the first prescaled tick after a start may come early
    // channel 0 clock
    always_comb begin
        case (st_r.c0.sel)
            `DPRPG_CS_CLK: begin
                tick0 = 1'b1;
            end
            `DPRPG_CS_DIV4: begin
                tick0 = (st_r.div[1:0] == `DPRPG_DIV4_END);
            end
            `DPRPG_CS_DIV16: begin
                tick0 = (st_r.div == `DPRPG_DIV16_END);
            end
            `DPRPG_CS_TB: begin
                tick0 = TB_TICK_I;
            end
            default: begin
                tick0 = 1'b0;
            end
        endcase
    end

    // channel 1 tick
    always_comb begin
        if (wide || presc) begin
            tick1 = borrow[0];
        end else begin
            tick1 = st_r.c1.csel1 ? TB_TICK_I : 1'b1;
        end
    end

    // ****************************************
    // channel engines
    // ****************************************

    // channel drive; in 16-bit mode channel 0 only reloads on the joint zero
    // joined reload values
    always_comb begin
        cfg[0].run        = st_r.c0.run;
        cfg[0].tick       = tick0;
        cfg[0].reload_now = wide ? (cnt[1] == `DPRPG_CNT_ZERO) : 1'b1;
        cfg[0].lo         = st_r.lo0;
        cfg[0].hi         = st_r.hi0;
        cfg[1].run        = st_r.c1.run;
        cfg[1].tick       = tick1;
        cfg[1].reload_now = 1'b1;
        cfg[1].lo         = st_r.lo1;
        cfg[1].hi         = st_r.hi1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            dprpg_chan u_chan (
                .clk_i    (CLK_I),
                .rst_b_i  (RST_B_I),
                .cfg_i    (cfg[gi]),
                .borrow_o (borrow[gi]),
                .level_o  (level[gi]),
                .cnt_o    (cnt[gi])
            );
        end
    endgenerate

    // wrap events feeding the flags
    always_comb begin
        if (wide) begin
            set0 = borrow[1];
            set1 = borrow[1];
        end else begin
            set0 = borrow[0];
            set1 = borrow[1];
        end
    end

    // ****************************************
    // apb slave and next state
    // ****************************************

    // zero wait states: answer is prepared in the setup cycle
    assign idx      = PADDR_I[9:`DPRPG_ADDR_LSB];
    assign rd_setup = PSEL_I && !PENABLE_I;
    assign wr_acc   = PSEL_I && PENABLE_I && st_r.pready && PWRITE_I;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.div    = st_r.div + `DPRPG_DIV_STEP;
        st_nxt.pready = rd_setup;
        // flags: set wins over a clearing write
        st_nxt.c0.flag = set0 | st_r.c0.flag;
        st_nxt.c1.flag = set1 | st_r.c1.flag;
        if (rd_setup) begin
            st_nxt.prdata  = `DPRPG_RST_WORD;
            st_nxt.pslverr = 1'b0;
            case (idx)
                `DPRPG_IDX_CTRL0: begin
                    st_nxt.prdata[`DPRPG_B_RUN]    = st_r.c0.run;
                    st_nxt.prdata[`DPRPG_B_PIN]    = st_r.c0.pin;
                    st_nxt.prdata[`DPRPG_B_IRQ]    = st_r.c0.irq;
                    st_nxt.prdata[`DPRPG_B_FLAG]   = st_r.c0.flag;
                    st_nxt.prdata[`DPRPG_B_SEL_HI] = st_r.c0.sel[1];
                    st_nxt.prdata[`DPRPG_B_SEL_LO] = st_r.c0.sel[0];
                    st_nxt.prdata[`DPRPG_B_RSV]    = 1'b1;
                end
                `DPRPG_IDX_CTRL1: begin
                    st_nxt.prdata[`DPRPG_B_RUN]    = st_r.c1.run;
                    st_nxt.prdata[`DPRPG_B_CSEL1]  = st_r.c1.csel1;
                    st_nxt.prdata[`DPRPG_B_PIN]    = st_r.c1.pin;
                    st_nxt.prdata[`DPRPG_B_IRQ]    = st_r.c1.irq;
                    st_nxt.prdata[`DPRPG_B_FLAG]   = st_r.c1.flag;
                    st_nxt.prdata[`DPRPG_B_SEL_HI] = st_r.mode[1];
                    st_nxt.prdata[`DPRPG_B_SEL_LO] = st_r.mode[0];
                    st_nxt.prdata[`DPRPG_B_RSV]    = 1'b1;
                end
                `DPRPG_IDX_LO0: begin
                    st_nxt.prdata[7:0] = st_r.lo0;
                end
                `DPRPG_IDX_HI0: begin
                    st_nxt.prdata[7:0] = st_r.hi0;
                end
                `DPRPG_IDX_LO1: begin
                    st_nxt.prdata[7:0] = st_r.lo1;
                end
                `DPRPG_IDX_HI1: begin
                    st_nxt.prdata[7:0] = st_r.hi1;
                end
                `DPRPG_IDX_COUNT: begin
                    st_nxt.prdata[15:0] = {cnt[1], cnt[0]};
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (idx)
                `DPRPG_IDX_CTRL0: begin
                    st_nxt.c0.run = PWDATA_I[`DPRPG_B_RUN];
                    st_nxt.c0.pin = PWDATA_I[`DPRPG_B_PIN];
                    st_nxt.c0.irq = PWDATA_I[`DPRPG_B_IRQ];
                    st_nxt.c0.sel = PWDATA_I[`DPRPG_B_SEL_HI:`DPRPG_B_SEL_LO];
                    st_nxt.c0.flag = set0 | (st_r.c0.flag & PWDATA_I[`DPRPG_B_FLAG]);
                end
                `DPRPG_IDX_CTRL1: begin
                    st_nxt.c1.run   = PWDATA_I[`DPRPG_B_RUN];
                    st_nxt.c1.csel1 = PWDATA_I[`DPRPG_B_CSEL1];
                    st_nxt.c1.pin   = PWDATA_I[`DPRPG_B_PIN];
                    st_nxt.c1.irq   = PWDATA_I[`DPRPG_B_IRQ];
                    st_nxt.mode     = PWDATA_I[`DPRPG_B_SEL_HI:`DPRPG_B_SEL_LO];
                    st_nxt.c1.flag  = set1 | (st_r.c1.flag & PWDATA_I[`DPRPG_B_FLAG]);
                end
                `DPRPG_IDX_LO0: begin
                    st_nxt.lo0 = PWDATA_I[7:0];
                end
                `DPRPG_IDX_HI0: begin
                    st_nxt.hi0 = PWDATA_I[7:0];
                end
                `DPRPG_IDX_LO1: begin
                    st_nxt.lo1 = PWDATA_I[7:0];
                end
                `DPRPG_IDX_HI1: begin
                    st_nxt.hi1 = PWDATA_I[7:0];
                end
                default: begin
                    st_nxt.lo0 = st_r.lo0;
                end
            endcase
        end
        st_nxt.out_a = wide ? level[1] : level[0];
        st_nxt.out_b = level[1];
        st_nxt.oe_a = st_r.c0.pin;
        st_nxt.oe_b = st_r.c1.pin;
        st_nxt.irq0 = st_r.c0.flag & st_r.c0.irq;
        st_nxt.irq1 = st_r.c1.flag & st_r.c1.irq;
    end

    // ****************************************
    // state register
    // ****************************************

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign PRDATA_O      = st_r.prdata;
    assign PREADY_O      = st_r.pready;
    assign PSLVERR_O     = st_r.pslverr;
    assign PULSE_OUT_A_O = st_r.out_a;
    assign PULSE_OE_A_O  = st_r.oe_a;
    assign PULSE_OUT_B_O = st_r.out_b;
    assign PULSE_OE_B_O  = st_r.oe_b;
    assign IRQ_CH0_O     = st_r.irq0;
    assign IRQ_CH1_O     = st_r.irq1;

endmodule

`default_nettype wire

//--- tb/dprpg_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// pin-level checks
// ****************
module dprpg_props (
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [9:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        TB_TICK_I,
    input wire logic        PULSE_OUT_A_O,
    input wire logic        PULSE_OE_A_O,
    input wire logic        PULSE_OUT_B_O,
    input wire logic        PULSE_OE_B_O,
    input wire logic        IRQ_CH0_O,
    input wire logic        IRQ_CH1_O
);
    logic wr0;
    logic wr1;
    logic run0_r;

    // control writes as the bus shows them; no wait states exist
    assign wr0 = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I[9:2] == 8'h30;
    assign wr1 = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I[9:2] == 8'h31;

    // shadow of the channel 0 run bit
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            run0_r <= 1'b0;
        end else if (wr0) begin
            run0_r <= PWDATA_I[7];
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    a_irq0_masked: assert property (wr0 && !PWDATA_I[4] |=> ##1 !IRQ_CH0_O)
        else $error("irq0 high while masked");
    a_irq1_masked: assert property (wr1 && !PWDATA_I[4] |=> ##1 !IRQ_CH1_O)
        else $error("irq1 high while masked");
    a_oe_a_follows: assert property (wr0 |=> ##1 PULSE_OE_A_O == $past(PWDATA_I[5], 2))
        else $error("pin a enable wrong");
    a_oe_b_follows: assert property (wr1 |=> ##1 PULSE_OE_B_O == $past(PWDATA_I[5], 2))
        else $error("pin b enable wrong");
    a_stop_holds_low: assert property (!run0_r && $past(!run0_r) && $past(!run0_r, 2) |-> !PULSE_OUT_A_O)
        else $error("pin a high while stopped");
    a_start_low_phase: assert property ($rose(run0_r) |-> !PULSE_OUT_A_O [*3])
        else $error("start did not begin low");
    a_rsv_reads_one: assert property (
        PREADY_O && !PWRITE_I && PADDR_I[9:3] == 7'h18 |-> PRDATA_O[0] && PRDATA_O[31:8] == 24'h0)
        else $error("control read wrong reserved bits");
    a_irq0_holds: assert property ($fell(IRQ_CH0_O) |-> $past(wr0, 2))
        else $error("irq0 dropped without a write");
endmodule

bind dprpg_top dprpg_props i_dprpg_props (
    .CLK_I         (CLK_I),
    .RST_B_I       (RST_B_I),
    .PSEL_I        (PSEL_I),
    .PENABLE_I     (PENABLE_I),
    .PWRITE_I      (PWRITE_I),
    .PADDR_I       (PADDR_I),
    .PWDATA_I      (PWDATA_I),
    .PRDATA_O      (PRDATA_O),
    .PREADY_O      (PREADY_O),
    .PSLVERR_O     (PSLVERR_O),
    .TB_TICK_I     (TB_TICK_I),
    .PULSE_OUT_A_O (PULSE_OUT_A_O),
    .PULSE_OE_A_O  (PULSE_OE_A_O),
    .PULSE_OUT_B_O (PULSE_OUT_B_O),
    .PULSE_OE_B_O  (PULSE_OE_B_O),
    .IRQ_CH0_O     (IRQ_CH0_O),
    .IRQ_CH1_O     (IRQ_CH1_O)
);
`default_nettype wire

//--- tb/dprpg_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************
// port logic behind a pin
// ************************
module dprpg_port_model (
    input  wire logic  clk_i,
    input  wire logic  rst_b_i,
    input  wire logic  out_i,
    input  wire logic  oe_i,
    output logic       pin_o,
    output logic [9:0] hi_len_o,
    output logic [9:0] lo_len_o
);
    logic       port_r;
    logic       prev_r;
    logic       prev_oe_r;
    logic [9:0] run_r;

    assign pin_o = oe_i ? out_i : port_r;

    // released pin toggles, so a stale level cannot look like a pulse
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_r   <= 1'b0;
            prev_r   <= 1'b0;
            prev_oe_r <= 1'b0;
            run_r    <= 10'h0;
            hi_len_o <= 10'h0;
            lo_len_o <= 10'h0;
        end else begin
            port_r <= ~port_r;
            prev_r <= pin_o;
            prev_oe_r <= oe_i;
            // a run that began while the port owned the pin is never a phase
            if (pin_o != prev_r || !oe_i || !prev_oe_r) begin
                run_r <= 10'h1;
                if (oe_i && prev_oe_r && prev_r)
                    hi_len_o <= run_r;
                else if (oe_i && prev_oe_r)
                    lo_len_o <= run_r;
            end else begin
                run_r <= run_r + 10'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/dprpg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ***************
// top-level bench
// ***************
module dprpg_top_bench;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tb_tick = 1'b0;
    logic [2:0]  tcnt = 3'h0;
    logic        out_a, oe_a, out_b, oe_b, irq0, irq1;
    logic [9:0]  hi_a, lo_a, hi_b, lo_b;
    logic [31:0] rdata;
    logic        rerr;
    int          errors = 0;
    int          check_count = 0;
    int          div[4] = '{1, 4, 16, 8};

    dprpg_top i_dprpg_top (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TB_TICK_I(tb_tick), .PULSE_OUT_A_O(out_a), .PULSE_OE_A_O(oe_a),
        .PULSE_OUT_B_O(out_b), .PULSE_OE_B_O(oe_b), .IRQ_CH0_O(irq0), .IRQ_CH1_O(irq1));
    dprpg_port_model i_model_a (.clk_i(clk), .rst_b_i(rst_b), .out_i(out_a), .oe_i(oe_a), .pin_o(),
        .hi_len_o(hi_a), .lo_len_o(lo_a));
    dprpg_port_model i_model_b (.clk_i(clk), .rst_b_i(rst_b), .out_i(out_b), .oe_i(oe_b), .pin_o(),
        .hi_len_o(hi_b), .lo_len_o(lo_b));

    // timebase tick every eighth clock
    always @(posedge clk) begin
        tcnt    <= tcnt + 3'h1;
        tb_tick <= (tcnt == 3'h7);
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one bus transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a wait
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // the slave answers in its first access cycle
        cmp(n, 32'd1, "wait states");
    endtask

    task automatic t_reset();
        cmp({irq1, irq0, oe_b, out_b, oe_a, out_a}, 32'h0, "idle pins");
        apb(1'b0, 8'h30, 32'h0);
        cmp(rdata, 32'h1, "ctrl0 reset");
        apb(1'b0, 8'h31, 32'h0);
        cmp(rdata, 32'h1, "ctrl1 reset");
        apb(1'b0, 8'h36, 32'h0);
        cmp(rdata, 32'h0, "count reset");
        apb(1'b0, 8'h3f, 32'h0);
        cmp(rerr, 1'b1, "unmapped error");
        $display("reset test done");
    endtask

    task automatic t_flag();
        apb(1'b1, 8'h32, 32'h1);
        apb(1'b1, 8'h33, 32'h0);
        apb(1'b1, 8'h30, 32'hb1);
        repeat (20) @(posedge clk);
        cmp(hi_a, 32'd1, "high width");
        cmp(lo_a, 32'd2, "low width");
        cmp(irq0, 1'b1, "irq0 raised");
        apb(1'b0, 8'h30, 32'h0);
        cmp(rdata[3], 1'b1, "flag0 set");
        apb(1'b1, 8'h30, 32'h39);
        repeat (3) @(posedge clk);
        cmp(irq0, 1'b1, "irq0 held");
        apb(1'b1, 8'h30, 32'h31);
        apb(1'b0, 8'h30, 32'h0);
        cmp(rdata[3], 1'b0, "flag0 cleared");
        cmp(irq0, 1'b0, "irq0 dropped");
        $display("flag test done");
    endtask

    task automatic t_clock();
        apb(1'b1, 8'h32, 32'h3);
        apb(1'b1, 8'h33, 32'h3);
        apb(1'b1, 8'h34, 32'h3);
        apb(1'b1, 8'h35, 32'h3);
        apb(1'b0, 8'h35, 32'h0);
        cmp(rdata, 32'h3, "reload readback");
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h30, 32'ha1 | (s << 1));
            repeat (300) @(posedge clk);
            cmp(hi_a, 4 * div[s], "ch0 clock width");
            apb(1'b1, 8'h30, 32'h01);
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, 8'h31, s ? 32'he1 : 32'ha1);
            repeat (300) @(posedge clk);
            cmp(hi_b, s ? 32 : 4, "ch1 clock width");
            cmp(irq1, 1'b0, "irq1 masked");
        end
        apb(1'b0, 8'h31, 32'h0);
        cmp(rdata[3], 1'b1, "flag1 set");
        apb(1'b1, 8'h31, 32'h01);
        $display("clock test done");
    endtask

    task automatic t_presc();
        apb(1'b1, 8'h32, 32'h1);
        apb(1'b1, 8'h33, 32'h1);
        apb(1'b1, 8'h34, 32'h2);
        apb(1'b1, 8'h35, 32'h2);
        apb(1'b1, 8'h31, 32'h63);
        apb(1'b1, 8'h30, 32'ha1);
        apb(1'b1, 8'h31, 32'hf3);
        repeat (100) @(posedge clk);
        cmp(hi_a, 32'd2, "prescaler toggle");
        cmp(hi_b, 32'd6, "prescaled width");
        cmp(irq1, 1'b1, "irq1 raised");
        apb(1'b1, 8'h31, 32'h03);
        apb(1'b1, 8'h30, 32'h01);
        $display("prescaler test done");
    endtask

    task automatic t_wide();
        apb(1'b1, 8'h32, 32'h0);
        apb(1'b1, 8'h34, 32'h1);
        apb(1'b1, 8'h33, 32'h2);
        apb(1'b1, 8'h35, 32'h0);
        apb(1'b1, 8'h31, 32'ha7);
        apb(1'b1, 8'h30, 32'ha1);
        repeat (700) @(posedge clk);
        cmp(hi_a, 32'd3, "wide high width");
        cmp(lo_b, 32'd257, "wide low width");
        apb(1'b0, 8'h30, 32'h0);
        cmp(rdata[3], 1'b1, "wide flag0");
        apb(1'b0, 8'h31, 32'h0);
        cmp(rdata[3], 1'b1, "wide flag1");
        $display("wide test done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst_b   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 10'h0;
        pwdata  = 32'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_flag();
        t_clock();
        t_presc();
        t_wide();
        wrap_up();
    end

    // runaway guard, well above the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
